// >>> inc/ft_sram_pkg.sv
package ft_sram_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int DEPTH = 1048576;
	localparam logic [1:0] BURST_ZERO = 2'h0;
	localparam logic [1:0] BURST_ONE = 2'h1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} cycle_state_t;

	typedef struct packed {
		logic processor_addr_strobe_n;
		logic controller_addr_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_gate_n;
		logic [1:0] byte_lane_write_n_vec;
		logic master_select_n;
		logic select_hi;
		logic select_lo_n;
	} bus_ctrl_t;
endpackage

// >>> core/ft_sram_array.sv
`timescale 1ns/1ps
module ft_sram_array
	import ft_sram_pkg::*;
(
	input wire logic clock_in,
	input wire logic enable_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [LANES-1:0] lane_we_in,
	input wire logic [DATA_W-1:0] wdata_in,
	output logic [DATA_W-1:0] rdata_out
);
	// one memory per lane keeps every array single-driven
	genvar g;
	for (g = 0; g < LANES; g++) begin : g_lane
		logic [LANE_W-1:0] mem_ff [0:DEPTH-1];
		logic [LANE_W-1:0] rd_ff;
		always_ff @(posedge clock_in) begin
			if (enable_in && lane_we_in[g]) begin
				mem_ff[addr_in] <= wdata_in[g*LANE_W +: LANE_W];
			end
		end
		// read before write when both hit one address on one edge
		always_ff @(posedge clock_in) begin
			if (enable_in) begin
				rd_ff <= mem_ff[addr_in];
			end
		end
		assign rdata_out[g*LANE_W +: LANE_W] = rd_ff;
	end
endmodule

// >>> core/ft_sram.sv
`timescale 1ns/1ps
// Functional notes
// - processor strobe low with selects active loads address, starts read.
// - read data flows from registered address to outputs, no extra stage.
// - burst advance ignored on processor strobe edge, sampled afterwards.
// - burst address steps when advance low and both strobes high.
// - order select high gives interleaved burst, low gives linear.
// - global write writes all 18 bits, lane writes ignored.
// - otherwise write only lanes asserted while byte write gate asserted.
// - lane writes ignored on processor strobe edge, sampled later.
// - any sampled lane write turns output buffers off.
// - bus data captured when a lane write is sampled low in an active cycle or on a controller strobe edge.
// - write burst advances when lane write and advance both low.
// - controller strobe cycle decides read or write on its own edge.
// - master select blocks processor strobe start, not controller start.
// - array is 1,048,576 words of 18 bits in two lanes.
// - second select active high, third active low, sampled at cycle start.
// - gate asserted with no lane active is a read.
// - sleep ignores inputs except reset, floats outputs, keeps contents.
module ft_sram
	import ft_sram_pkg::*;
(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	input wire bus_ctrl_t ctrl_in,
	input wire logic burst_order_select_n_in,
	input wire logic output_enable_n_in,
	input wire logic sleep_request_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic [DATA_W-1:0] dq_oe_out
);
	cycle_state_t state_ff;
	cycle_state_t nxt_state;
	logic [ADDR_W-1:0] base_addr_ff;
	logic [1:0] count_ff;
	logic [1:0] nxt_count;
	logic [1:0] burst_low;
	logic [ADDR_W-1:0] cur_addr;
	logic [DATA_W-1:0] wdata;
	logic [LANES-1:0] lane_we;
	logic [DATA_W-1:0] rdata;
	logic run;
	logic sel_ok;
	logic start_p;
	logic start_c;
	logic start;
	logic any_lane;
	logic write_cmd;
	logic lanes_sampled;
	logic out_block_ff;

	// sleep freezes everything except the sleep pin itself and reset
	assign run = clk_en_in && !sleep_request_in;

	assign sel_ok = !ctrl_in.master_select_n && ctrl_in.select_hi && !ctrl_in.select_lo_n;
	// master select gates only this path
	assign start_p = !ctrl_in.processor_addr_strobe_n && sel_ok;
	// controller start needs processor strobe high
	assign start_c = !ctrl_in.controller_addr_strobe_n && ctrl_in.processor_addr_strobe_n
		&& ctrl_in.select_hi && !ctrl_in.select_lo_n;
	assign start = start_p || start_c;

	// lanes not sampled on processor strobe edge
	assign lanes_sampled = ctrl_in.processor_addr_strobe_n;
	assign any_lane = !ctrl_in.byte_write_gate_n && (ctrl_in.byte_lane_write_n_vec != 2'h3);
	// write decided on controller strobe edge too
	assign write_cmd = lanes_sampled && (!ctrl_in.global_write_n || any_lane);

	always_comb begin
		lane_we = '0;
		if (run && write_cmd && state_ff != ST_IDLE || run && start_c && write_cmd) begin
			if (!ctrl_in.global_write_n) begin
				lane_we = {LANES{1'b1}};
			end else begin
				lane_we = ~ctrl_in.byte_lane_write_n_vec;
			end
		end
	end

	assign wdata = dq_in;

	// interleaved xor, linear add mod four
	// order select
	// the edge that steps the count also uses the stepped address
	assign burst_low = burst_order_select_n_in ? (base_addr_ff[1:0] ^ nxt_count)
		: 2'(base_addr_ff[1:0] + nxt_count);
	assign cur_addr = start ? addr_in : {base_addr_ff[ADDR_W-1:2], burst_low};

	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		if (start) begin
			nxt_count = BURST_ZERO;
			nxt_state = write_cmd ? ST_WRITE : ST_READ;
		end else if (state_ff != ST_IDLE) begin
			nxt_state = write_cmd ? ST_WRITE : ST_READ;
			if (!ctrl_in.burst_advance_n && ctrl_in.controller_addr_strobe_n
				&& ctrl_in.processor_addr_strobe_n) begin
				nxt_count = 2'(count_ff + BURST_ONE);
			end
		end
		case (state_ff)
			ST_IDLE, ST_READ, ST_WRITE: ;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			state_ff <= ST_IDLE;
			count_ff <= BURST_ZERO;
		end else if (run) begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			base_addr_ff <= '0;
		end else if (run && start) begin
			base_addr_ff <= addr_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			out_block_ff <= 1'b1;
		end else if (run) begin
			out_block_ff <= write_cmd || !(start || state_ff != ST_IDLE);
		end
	end

	// registered address read, flows straight out
	ft_sram_array u_array (
		.clock_in(clock_in),
		.enable_in(run),
		.addr_in(cur_addr),
		.lane_we_in(lane_we),
		.wdata_in(wdata),
		.rdata_out(rdata)
	);

	// sleep floats outputs
	// output enable acts asynchronously, so it stays outside the flops
	assign dq_out = rdata;
	assign dq_oe_out = {DATA_W{!output_enable_n_in && !out_block_ff && !sleep_request_in}};

	AST_SLEEP_FLOAT: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sleep_request_in |-> dq_oe_out == '0)
		else $error("outputs driven in sleep");

	AST_WRITE_BLOCK: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && write_cmd |=> dq_oe_out == '0)
		else $error("outputs on after write");

	AST_START_LOAD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && start |=> base_addr_ff == $past(addr_in))
		else $error("address not loaded");

	AST_START_ZERO: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && start |=> count_ff == BURST_ZERO)
		else $error("count not cleared");

	AST_ADV_STEP: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && !start && state_ff != ST_IDLE && !ctrl_in.burst_advance_n
		&& ctrl_in.controller_addr_strobe_n && ctrl_in.processor_addr_strobe_n
		|=> count_ff == 2'($past(count_ff) + 2'h1))
		else $error("burst did not advance");

	AST_GLOBAL_ALL: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && lane_we != '0 && !ctrl_in.global_write_n |-> lane_we == 2'h3)
		else $error("global write partial");

	AST_LANE_IGNORE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && !ctrl_in.processor_addr_strobe_n && sel_ok |=> state_ff == ST_READ)
		else $error("processor start not read");

	AST_MASTER_BLOCK: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && state_ff == ST_IDLE && ctrl_in.master_select_n
		&& ctrl_in.controller_addr_strobe_n |=> state_ff == ST_IDLE)
		else $error("deselected start");

	AST_INTERLEAVE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		burst_order_select_n_in && !start |-> cur_addr[1:0] == (base_addr_ff[1:0] ^ nxt_count))
		else $error("interleave order wrong");

	AST_SLEEP_STATE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sleep_request_in |=> state_ff == $past(state_ff))
		else $error("state moved in sleep");

	AST_SLEEP_COUNT: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sleep_request_in |=> count_ff == $past(count_ff))
		else $error("count moved in sleep");

	AST_SLEEP_ADDR: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sleep_request_in |=> base_addr_ff == $past(base_addr_ff))
		else $error("address moved in sleep");

	AST_SLEEP_NO_WRITE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sleep_request_in |-> lane_we == '0)
		else $error("write during sleep");

	AST_DATA_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!run |=> dq_out == $past(dq_out))
		else $error("read data moved while frozen");

	AST_LANE_START: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!ctrl_in.processor_addr_strobe_n |-> lane_we == '0)
		else $error("lane write on processor edge");

	AST_CTRL_WRITE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && start_c && write_cmd |-> lane_we != '0)
		else $error("controller write dropped");

	AST_CTRL_ADDR: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && start_c |-> cur_addr == addr_in)
		else $error("controller start address wrong");

	AST_ADV_IGNORED: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && start_p && !ctrl_in.burst_advance_n |=> count_ff == BURST_ZERO)
		else $error("advance taken on start edge");

	AST_ADV_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && !start && ctrl_in.burst_advance_n |=> count_ff == $past(count_ff))
		else $error("count moved without advance");

	AST_ADV_STROBE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && !start && !ctrl_in.controller_addr_strobe_n |=> count_ff == $past(count_ff))
		else $error("count moved with strobe low");

	AST_LINEAR: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!burst_order_select_n_in && !start
		|-> cur_addr[1:0] == 2'(base_addr_ff[1:0] + nxt_count))
		else $error("linear order wrong");

	AST_HIGH_BITS: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!start |-> cur_addr[ADDR_W-1:2] == base_addr_ff[ADDR_W-1:2])
		else $error("burst changed high address bits");

	AST_LANE_PICK: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && lane_we != '0 && ctrl_in.global_write_n
		|-> lane_we == ~ctrl_in.byte_lane_write_n_vec)
		else $error("wrong lanes written");

	AST_GATE_OFF: assert property (@(posedge clock_in) disable iff (!resetn_in)
		ctrl_in.global_write_n && ctrl_in.byte_write_gate_n |-> lane_we == '0)
		else $error("write with gate off");

	AST_NO_LANE_READ: assert property (@(posedge clock_in) disable iff (!resetn_in)
		ctrl_in.global_write_n && ctrl_in.byte_lane_write_n_vec == 2'h3 |-> lane_we == '0)
		else $error("write with no lane");

	AST_OE_PIN: assert property (@(posedge clock_in) disable iff (!resetn_in)
		output_enable_n_in |-> dq_oe_out == '0)
		else $error("outputs on with enable off");

	AST_CTRL_MASTER: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && start_c && ctrl_in.master_select_n |=> base_addr_ff == $past(addr_in))
		else $error("controller start blocked by master");

	AST_SEL_HI: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && state_ff == ST_IDLE && !ctrl_in.select_hi |=> state_ff == ST_IDLE)
		else $error("start with second select off");

	AST_SEL_LO: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && state_ff == ST_IDLE && ctrl_in.select_lo_n |=> state_ff == ST_IDLE)
		else $error("start with third select off");

	AST_WRITE_ADV: assert property (@(posedge clock_in) disable iff (!resetn_in)
		run && !start && lane_we != '0 && !ctrl_in.burst_advance_n
		&& ctrl_in.processor_addr_strobe_n && ctrl_in.controller_addr_strobe_n
		|=> count_ff == 2'($past(count_ff) + 2'h1))
		else $error("write burst did not advance");

	// main scenarios reached
	COV_READ: cover property (@(posedge clock_in) start_p ##1 state_ff == ST_READ);
	COV_WRITE: cover property (@(posedge clock_in) start_c && write_cmd);
	COV_BURST: cover property (@(posedge clock_in) count_ff == 2'h3);
	COV_SLEEP: cover property (@(posedge clock_in) sleep_request_in);
	COV_LINEAR: cover property (@(posedge clock_in) !burst_order_select_n_in && count_ff == 2'h3);
endmodule

// >>> sim/ft_sram_master.sv
`timescale 1ns/1ps
module ft_sram_master
	import ft_sram_pkg::*;
(
	input wire logic clock_in,
	output bus_ctrl_t ctrl_out,
	output logic [ADDR_W-1:0] addr_out,
	output logic [DATA_W-1:0] wdata_out,
	output logic oe_n_out
);
	initial begin
		ctrl_out = bus_ctrl_t'(10'h3fa);
		addr_out = '0;
		wdata_out = '0;
		oe_n_out = 1'b1;
	end
	task automatic cyc(input logic [9:0] c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		bus_ctrl_t s;
		logic w;
		s = bus_ctrl_t'(c);
		s.processor_addr_strobe_n = s.processor_addr_strobe_n | ~s.controller_addr_strobe_n;
		w = ~s.global_write_n | (~s.byte_write_gate_n & ~&s.byte_lane_write_n_vec);
		@(posedge clock_in);
		ctrl_out <= s;
		addr_out <= a;
		oe_n_out <= w;
		// a released bus toggles so stale data never looks valid
		wdata_out <= w ? d : ~wdata_out;
	endtask
endmodule

// >>> sim/flowthrough_burst_sync_sram_test.sv
`timescale 1ns/1ps
module flowthrough_burst_sync_sram_test
	import ft_sram_pkg::*;
;
	localparam logic [ADDR_W-1:0] B = 20'h1_2344;
	logic clock_in, resetn_in, order_n, sleep, oe_n;
	bus_ctrl_t ctrl;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, dq_out, dq_oe;
	int n_fail = 0, comparisons = 0, cycles = 0;

	ft_sram_master host(.clock_in(clock_in), .ctrl_out(ctrl), .addr_out(addr),
		.wdata_out(wdata), .oe_n_out(oe_n));
	ft_sram i_dut(.clock_in(clock_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
		.ctrl_in(ctrl), .burst_order_select_n_in(order_n), .output_enable_n_in(oe_n),
		.sleep_request_in(sleep), .addr_in(addr), .dq_in(wdata), .dq_out(dq_out),
		.dq_oe_out(dq_oe));

	function automatic logic [DATA_W-1:0] wd(input logic [ADDR_W-1:0] a);
		return a[DATA_W-1:0] ^ 18'h2_d5a3;
	endfunction
	task automatic chk(input string n, input logic [DATA_W-1:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic write_words();
		for (int i = 0; i < 4; i++)
			host.cyc(i[0] ? 10'h2b6 : 10'h2b2, B + 20'(i), wd(B + 20'(i)));
	endtask
	task automatic read_burst(input logic o);
		logic [1:0] lo;
		order_n <= o;
		host.cyc(10'h13a, B + 20'h0_0001, '0);
		for (int k = 0; k < 4; k++) begin
			host.cyc(k < 3 ? 10'h37a : 10'h3fa, B, '0);
			@(negedge clock_in);
			lo = o ? 2'(1 ^ k) : 2'(1 + k);
			chk("burst word", wd({B[19:2], lo}), dq_out);
			chk("burst oe", 18'h3_ffff, dq_oe);
		end
	endtask
	task automatic lane_write();
		host.cyc(10'h1c2, B, '0);
		host.cyc(10'h3d2, B, '0);
		@(negedge clock_in);
		chk("lanes on start", wd(B), dq_out);
		host.cyc(10'h1fa, B, '0);
		host.cyc(10'h3fa, B, '0);
		@(negedge clock_in);
		chk("lane0 only", wd(B) & 18'h3_fe00, dq_out);
		host.cyc(10'h2da, B + 20'h0_0001, '0);
		host.cyc(10'h3fa, B, '0);
		@(negedge clock_in);
		chk("gate no lane", wd(B + 20'h0_0001), dq_out);
		chk("gate no lane oe", 18'h3_ffff, dq_oe);
	endtask
	task automatic blocked_start();
		host.cyc(10'h1fe, B + 20'h0_0002, '0);
		host.cyc(10'h3fa, B, '0);
		@(negedge clock_in);
		chk("blocked start", wd(B + 20'h0_0001), dq_out);
	endtask
	task automatic sleep_hold();
		@(posedge clock_in);
		sleep <= 1'b1;
		host.cyc(10'h2b2, B + 20'h0_0002, '0);
		host.cyc(10'h3fa, B, '0);
		@(negedge clock_in);
		chk("sleep float", 18'h0_0000, dq_oe);
		@(posedge clock_in);
		sleep <= 1'b0;
		host.cyc(10'h2fa, B + 20'h0_0002, '0);
		host.cyc(10'h3fa, B, '0);
		@(negedge clock_in);
		chk("sleep kept", wd(B + 20'h0_0002), dq_out);
	endtask

	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	// hang guard: the whole run needs well under a hundred cycles
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		resetn_in = 1'b0;
		order_n = 1'b1;
		sleep = 1'b0;
		repeat (4) @(posedge clock_in);
		resetn_in <= 1'b1;
		write_words();
		read_burst(1'b1);
		read_burst(1'b0);
		lane_write();
		blocked_start();
		sleep_hold();
		end_of_test();
	end
endmodule
